// ---- core/mxbt_seq.sv ----
// Multiplexed expansion bus master: strobe sequencer on the bus clock
`timescale 1ns/1ps
module mxbt_seq (
   // System clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Expansion bus clock
   input wire logic exp_clk,
   // Phase lengths, each value plus one cycles
   input wire logic [mxbt_pkg::SHORT_LEN_W-1:0] address_phase_len,
   input wire logic [mxbt_pkg::SHORT_LEN_W-1:0] cs_delay_len,
   input wire logic [mxbt_pkg::SHORT_LEN_W-1:0] data_setup_phase_len,
   input wire logic [mxbt_pkg::LONG_LEN_W-1:0] data_strobe_phase_len,
   input wire logic [mxbt_pkg::SHORT_LEN_W-1:0] data_hold_phase_len,
   input wire logic [mxbt_pkg::LONG_LEN_W-1:0] recovery_phase_len,
   // Access request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [mxbt_pkg::AD_W-1:0] req_addr,
   input wire logic [mxbt_pkg::AD_W-1:0] req_wdata,
   // Access completion
   output logic resp_valid,
   output logic [mxbt_pkg::AD_W-1:0] resp_rdata,
   // Expansion bus pins
   output logic address_latch_strobe,
   output logic chip_select_n,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic [mxbt_pkg::AD_W-1:0] ad_out,
   output logic ad_oe,
   input wire logic [mxbt_pkg::AD_W-1:0] ad_in
);

   // System side: request held stable while the link runs it
   logic busy_q;
   logic req_tgl_q;
   logic wr_q;
   logic [mxbt_pkg::AD_W-1:0] addr_q;
   logic [mxbt_pkg::AD_W-1:0] wdata_q;
   logic [1:0] t_ale_q;
   logic [1:0] t_cs_q;
   logic [1:0] t_setup_q;
   logic [1:0] t_hold_q;
   logic [3:0] t_strobe_q;
   logic [3:0] t_recov_q;
   logic [2:0] done_sync_q;
   logic resp_valid_q;
   logic [mxbt_pkg::AD_W-1:0] resp_rdata_q;

   wire accept = req_valid && !busy_q;
   wire done_evt = done_sync_q[2] ^ done_sync_q[1];
   assign req_ready = !busy_q;
   assign resp_valid = resp_valid_q;
   assign resp_rdata = resp_rdata_q;

   // Link side declarations
   logic [1:0] rst_sync_q;
   logic [2:0] req_sync_q;
   logic done_tgl_q;
   mxbt_pkg::mxbt_state_type state_q;
   mxbt_pkg::mxbt_state_type state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [mxbt_pkg::AD_W-1:0] ad_s1_q;
   logic [mxbt_pkg::AD_W-1:0] ad_s2_q;
   logic [mxbt_pkg::CAP_DELAY-1:0] cap_q;
   logic [mxbt_pkg::AD_W-1:0] rdata_q;
   logic ale_q;
   logic cs_n_q;
   logic wr_n_q;
   logic rd_n_q;
   logic oe_q;
   logic [mxbt_pkg::AD_W-1:0] ad_q;

   wire rst_link = rst_sync_q[1];
   wire start_evt = req_sync_q[2] ^ req_sync_q[1];
   wire cnt_zero = (cnt_q == 4'h0);

   // Busy from accept until the link reports the access done
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else if (accept) begin
         busy_q <= 1'b1;
      end else if (done_evt) begin
         busy_q <= 1'b0;
      end
   end

   // Request word held stable for the link while busy
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         req_tgl_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= mxbt_pkg::AD_RST;
         wdata_q <= mxbt_pkg::AD_RST;
      end else if (accept) begin
         req_tgl_q <= ~req_tgl_q;
         wr_q <= req_write;
         addr_q <= req_addr;
         wdata_q <= req_wdata;
      end
   end

   // Lengths taken at accept; later changes wait for the next access
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         t_ale_q <= 2'h0;
         t_cs_q <= 2'h0;
         t_setup_q <= 2'h0;
         t_hold_q <= 2'h0;
         t_strobe_q <= 4'h0;
         t_recov_q <= 4'h0;
      end else if (accept) begin
         t_ale_q <= address_phase_len;
         t_cs_q <= cs_delay_len;
         t_setup_q <= data_setup_phase_len;
         t_hold_q <= data_hold_phase_len;
         t_strobe_q <= data_strobe_phase_len;
         t_recov_q <= recovery_phase_len;
      end
   end

   // Completion comes back as a toggle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         done_sync_q <= 3'h0;
         resp_valid_q <= 1'b0;
         resp_rdata_q <= mxbt_pkg::AD_RST;
      end else begin
         done_sync_q <= {done_sync_q[1:0], done_tgl_q};
         resp_valid_q <= done_evt;
         if (done_evt) begin
            // Link holds its read word stable until the next start
            resp_rdata_q <= rdata_q;
         end
      end
   end

   // Link side: whole sequencer runs on the bus clock, one count per period
   always_ff @(posedge exp_clk) begin
      rst_sync_q <= {rst_sync_q[0], sys_rst};
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q - 4'h1;
      case (state_q)
         mxbt_pkg::MXBT_IDLE: begin
            cnt_d = mxbt_pkg::CNT_RST;
            if (start_evt) begin
               state_d = mxbt_pkg::MXBT_ALE;
               cnt_d = {2'b00, t_ale_q};
            end
         end
         mxbt_pkg::MXBT_ALE: begin
            if (cnt_zero) begin
               state_d = mxbt_pkg::MXBT_AHOLD;
               cnt_d = mxbt_pkg::ADDR_HOLD_CNT;
            end
         end
         mxbt_pkg::MXBT_AHOLD: begin
            if (t_cs_q == 2'h0) begin
               state_d = mxbt_pkg::MXBT_SETUP;
               cnt_d = {2'b00, t_setup_q};
            end else begin
               state_d = mxbt_pkg::MXBT_CSWAIT;
               cnt_d = {2'b00, t_cs_q - 2'h1};
            end
         end
         mxbt_pkg::MXBT_CSWAIT: begin
            if (cnt_zero) begin
               state_d = mxbt_pkg::MXBT_SETUP;
               cnt_d = {2'b00, t_setup_q};
            end
         end
         mxbt_pkg::MXBT_SETUP: begin
            if (cnt_zero) begin
               state_d = mxbt_pkg::MXBT_STROBE;
               cnt_d = t_strobe_q;
            end
         end
         mxbt_pkg::MXBT_STROBE: begin
            if (cnt_zero) begin
               state_d = mxbt_pkg::MXBT_DHOLD;
               cnt_d = {2'b00, t_hold_q};
            end
         end
         mxbt_pkg::MXBT_DHOLD: begin
            if (cnt_zero) begin
               state_d = mxbt_pkg::MXBT_RECOV;
               cnt_d = t_recov_q;
            end
         end
         mxbt_pkg::MXBT_RECOV: begin
            if (cnt_zero) begin
               state_d = mxbt_pkg::MXBT_IDLE;
               cnt_d = mxbt_pkg::CNT_RST;
            end
         end
         default: begin
            state_d = mxbt_pkg::MXBT_IDLE;
            cnt_d = mxbt_pkg::CNT_RST;
         end
      endcase
   end

   // Pin levels registered from the next state, so no pin glitches
   wire in_addr = (state_d == mxbt_pkg::MXBT_ALE) || (state_d == mxbt_pkg::MXBT_AHOLD);
   wire in_sel = (state_d == mxbt_pkg::MXBT_CSWAIT) || (state_d == mxbt_pkg::MXBT_SETUP)
      || (state_d == mxbt_pkg::MXBT_STROBE) || (state_d == mxbt_pkg::MXBT_DHOLD);
   wire in_cs = in_sel && (state_d != mxbt_pkg::MXBT_CSWAIT);
   wire in_strobe = (state_d == mxbt_pkg::MXBT_STROBE);
   wire drive_data = wr_q && in_cs;
   // Address stays on the bus during the select wait so the bus floats mid access only in the data phases of a read
   wire drive_addr = in_addr || (state_d == mxbt_pkg::MXBT_CSWAIT);
   wire [mxbt_pkg::AD_W-1:0] ad_d = drive_data ? wdata_q : (drive_addr ? addr_q : ad_q);
   // Read word sampled at the last strobe edge, seen two syncs later
   wire cap_now = (state_q == mxbt_pkg::MXBT_STROBE) && cnt_zero && !wr_q;

   // Phase state and its down counter
   always_ff @(posedge exp_clk) begin
      if (rst_link) begin
         state_q <= mxbt_pkg::MXBT_IDLE;
         cnt_q <= mxbt_pkg::CNT_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Start toggle resynchronised; done toggles as recovery ends
   always_ff @(posedge exp_clk) begin
      if (rst_link) begin
         req_sync_q <= 3'h0;
         done_tgl_q <= 1'b0;
      end else begin
         req_sync_q <= {req_sync_q[1:0], req_tgl_q};
         if ((state_q == mxbt_pkg::MXBT_RECOV) && cnt_zero) begin
            done_tgl_q <= ~done_tgl_q;
         end
      end
   end

   // Bus input passes two flops before the read word takes it
   always_ff @(posedge exp_clk) begin
      if (rst_link) begin
         ad_s1_q <= mxbt_pkg::AD_RST;
         ad_s2_q <= mxbt_pkg::AD_RST;
         cap_q <= '0;
         rdata_q <= mxbt_pkg::AD_RST;
      end else begin
         ad_s1_q <= ad_in;
         ad_s2_q <= ad_s1_q;
         cap_q <= {cap_q[0], cap_now};
         if (cap_q[1]) begin
            rdata_q <= ad_s2_q;
         end
      end
   end

   // Latch, select and strobes
   always_ff @(posedge exp_clk) begin
      if (rst_link) begin
         ale_q <= 1'b0;
         cs_n_q <= mxbt_pkg::STROBE_N_RST;
         wr_n_q <= mxbt_pkg::STROBE_N_RST;
         rd_n_q <= mxbt_pkg::STROBE_N_RST;
      end else begin
         ale_q <= (state_d == mxbt_pkg::MXBT_ALE);
         cs_n_q <= !in_cs;
         wr_n_q <= !(in_strobe && wr_q);
         rd_n_q <= !(in_strobe && !wr_q);
      end
   end

   // Bus word and its enable
   always_ff @(posedge exp_clk) begin
      if (rst_link) begin
         oe_q <= 1'b0;
         ad_q <= mxbt_pkg::AD_RST;
      end else begin
         oe_q <= drive_addr || drive_data;
         ad_q <= ad_d;
      end
   end

   assign address_latch_strobe = ale_q;
   assign chip_select_n = cs_n_q;
   assign write_strobe_n = wr_n_q;
   assign read_strobe_n = rd_n_q;
   assign ad_out = ad_q;
   assign ad_oe = oe_q;

endmodule

// ---- core/mxbt_pkg.sv ----
// Shared constants and types for the multiplexed expansion bus sequencer
package mxbt_pkg;
   localparam int AD_W = 16;
   localparam int SHORT_LEN_W = 2;
   localparam int LONG_LEN_W = 4;
   localparam logic [3:0] ADDR_HOLD_CNT = 4'h0;
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [AD_W-1:0] AD_RST = 16'h0000;
   localparam logic STROBE_N_RST = 1'b1;
   localparam int CAP_DELAY = 2;

   typedef enum logic [2:0] {
      MXBT_IDLE,
      MXBT_ALE,
      MXBT_AHOLD,
      MXBT_CSWAIT,
      MXBT_SETUP,
      MXBT_STROBE,
      MXBT_DHOLD,
      MXBT_RECOV
   } mxbt_state_type;
endpackage

// ---- tb/mxbt_periph.sv ----
// Peripheral model at the far side of the multiplexed bus
`timescale 1ns/1ps
module mxbt_periph (
   // Bus clock
   input wire logic exp_clk,
   // Pins from the master
   input wire logic address_latch_strobe,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [15:0] ad_out,
   input wire logic ad_oe,
   // Resolved bus and captured words
   output logic [15:0] ad_in,
   output logic [15:0] cap_addr,
   output logic [15:0] cap_wdata
);
   logic ale_q = 1'b0;
   logic [15:0] pat_q = 16'h0000;
   // Released bus wanders so a late sample cannot pass by luck
   assign ad_in = ad_oe ? ad_out : (!read_strobe_n && !chip_select_n) ? cap_addr ^ 16'hc3a5 : pat_q;
   always_ff @(posedge exp_clk) begin
      ale_q <= address_latch_strobe;
      pat_q <= pat_q + 16'h3579;
      if (address_latch_strobe && !ale_q) cap_addr <= ad_out;
      if (!write_strobe_n) cap_wdata <= ad_out;
   end
endmodule

// ---- tb/mxbt_seq_sva.sv ----
// Pin timing checker for the bus sequencer
`timescale 1ns/1ps
module mxbt_chk (
   // Clock and reset
   input wire logic exp_clk,
   input wire logic sys_rst,
   // Phase lengths
   input wire logic [1:0] address_phase_len,
   input wire logic [1:0] cs_delay_len,
   input wire logic [1:0] data_setup_phase_len,
   input wire logic [3:0] data_strobe_phase_len,
   input wire logic [1:0] data_hold_phase_len,
   input wire logic [3:0] recovery_phase_len,
   // Bus pins
   input wire logic address_latch_strobe,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [15:0] ad_out,
   input wire logic ad_oe
);
   logic [4:0] pins_q;
   logic [4:0] run_q;
   logic [3:0] rst_q;
   logic [3:0] rec_len_q;
   wire [4:0] pins = {address_latch_strobe, chip_select_n, write_strobe_n, read_strobe_n, ad_oe};
   // Length of the pin state that just ended; saturates so long idles stay valid
   always_ff @(posedge exp_clk) begin
      pins_q <= sys_rst ? 5'h0e : pins;
      run_q <= (sys_rst || pins != pins_q) ? 5'h01 : run_q + {4'h0, run_q != 5'h1f};
      rst_q <= {rst_q[2:0], sys_rst};
      // Recovery length of the access in flight, kept for the next latch
      rec_len_q <= sys_rst ? 4'h0 : (chip_select_n ? rec_len_q : recovery_phase_len);
   end
   // Link leaves reset some bus edges late; pins unknown before that
   wire chk_off = sys_rst || (|rst_q);
   default clocking cb @(posedge exp_clk); endclocking
   default disable iff (chk_off);
   sequence s_ale_end;
      $fell(address_latch_strobe);
   endsequence
   property p_ale_len;
      s_ale_end |-> run_q == address_phase_len + 5'h1;
   endproperty
   property p_ale_addr;
      $rose(address_latch_strobe) |-> ad_oe && chip_select_n;
   endproperty
   property p_addr_hold;
      s_ale_end |-> ad_oe && $stable(ad_out) && chip_select_n;
   endproperty
   property p_cs_delay;
      $fell(chip_select_n) |-> run_q == cs_delay_len + 5'h1;
   endproperty
   property p_setup;
      $fell(write_strobe_n) || $fell(read_strobe_n) |-> run_q == data_setup_phase_len + 5'h1;
   endproperty
   property p_strobe;
      $rose(write_strobe_n) || $rose(read_strobe_n) |-> run_q == data_strobe_phase_len + 5'h1;
   endproperty
   property p_wdata;
      !write_strobe_n |-> ad_oe && $stable(ad_out);
   endproperty
   property p_hold;
      $rose(chip_select_n) |-> run_q == data_hold_phase_len + 5'h1;
   endproperty
   property p_recov;
      $rose(address_latch_strobe) |-> run_q >= rec_len_q + 5'h1;
   endproperty
   a_ale_len: assert property (p_ale_len) else $error("latch width wrong");
   a_ale_addr: assert property (p_ale_addr) else $error("no address at latch");
   a_addr_hold: assert property (p_addr_hold) else $error("address hold lost");
   a_cs_delay: assert property (p_cs_delay) else $error("select delay wrong");
   a_setup: assert property (p_setup) else $error("setup length wrong");
   a_strobe: assert property (p_strobe) else $error("strobe width wrong");
   a_wdata: assert property (p_wdata) else $error("write data moved");
   a_hold: assert property (p_hold) else $error("hold length wrong");
   a_recov: assert property (p_recov) else $error("recovery too short");
endmodule
bind mxbt_seq mxbt_chk i_mxbt_chk (
   .exp_clk(exp_clk),
   .sys_rst(sys_rst),
   .address_phase_len(address_phase_len),
   .cs_delay_len(cs_delay_len),
   .data_setup_phase_len(data_setup_phase_len),
   .data_strobe_phase_len(data_strobe_phase_len),
   .data_hold_phase_len(data_hold_phase_len),
   .recovery_phase_len(recovery_phase_len),
   .address_latch_strobe(address_latch_strobe),
   .chip_select_n(chip_select_n),
   .write_strobe_n(write_strobe_n),
   .read_strobe_n(read_strobe_n),
   .ad_out(ad_out),
   .ad_oe(ad_oe)
);

// ---- tb/test_muxed_expansion_bus_timing.sv ----
// Self-checking bench: corner and random accesses
`timescale 1ns/1ps
module test_muxed_expansion_bus_timing;
   logic ref_clk = 1'b0;
   logic exp_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0] address_phase_len = 2'h0;
   logic [1:0] cs_delay_len = 2'h0;
   logic [1:0] data_setup_phase_len = 2'h0;
   logic [1:0] data_hold_phase_len = 2'h0;
   logic [3:0] data_strobe_phase_len = 4'h0;
   logic [3:0] recovery_phase_len = 4'h0;
   logic req_ready, resp_valid, address_latch_strobe, chip_select_n;
   logic write_strobe_n, read_strobe_n, ad_oe;
   logic [15:0] resp_rdata, ad_out, ad_in, cap_addr, cap_wdata;
   int mismatches = 0;
   int total_checks = 0;
   mxbt_seq i_mxbt_seq (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .exp_clk(exp_clk),
      .address_phase_len(address_phase_len),
      .cs_delay_len(cs_delay_len),
      .data_setup_phase_len(data_setup_phase_len),
      .data_strobe_phase_len(data_strobe_phase_len),
      .data_hold_phase_len(data_hold_phase_len),
      .recovery_phase_len(recovery_phase_len),
      .req_valid(req_valid),
      .req_ready(req_ready),
      .req_write(req_write),
      .req_addr(req_addr),
      .req_wdata(req_wdata),
      .resp_valid(resp_valid),
      .resp_rdata(resp_rdata),
      .address_latch_strobe(address_latch_strobe),
      .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n),
      .ad_out(ad_out),
      .ad_oe(ad_oe),
      .ad_in(ad_in)
   );
   mxbt_periph i_mxbt_periph (
      .exp_clk(exp_clk),
      .address_latch_strobe(address_latch_strobe),
      .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n),
      .ad_out(ad_out),
      .ad_oe(ad_oe),
      .ad_in(ad_in),
      .cap_addr(cap_addr),
      .cap_wdata(cap_wdata)
   );
   initial forever #2.5 ref_clk = ~ref_clk;
   // Odd offset keeps the two clocks out of step
   initial #1.3 forever #6 exp_clk = ~exp_clk;
   function automatic logic [15:0] rd_word(input logic [15:0] a);
      return a ^ 16'hc3a5;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                         input logic [15:0] l);
      int n;
      {address_phase_len, cs_delay_len, data_setup_phase_len, data_hold_phase_len,
       data_strobe_phase_len, recovery_phase_len} = l;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      @(posedge ref_clk);
      #1 req_valid = 1'b0;
      check({15'h0000, req_ready}, 16'h0000);
      for (n = 0; n < 3000 && resp_valid !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
      end
      if (n == 3000) begin
         mismatches++;
         wrap_up();
      end
      check(cap_addr, a);
      if (wr) check(cap_wdata, d);
      else check(resp_rdata, rd_word(a));
      $display("access %h done", a);
   endtask
   initial begin
      void'($urandom(11));
      repeat (8) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      access(1'b1, 16'h0001, 16'hfffe, 16'h0000);
      access(1'b0, 16'hffff, 16'h0000, 16'hffff);
      access(1'b0, 16'h8000, 16'h0000, 16'h0000);
      access(1'b1, 16'h7fff, 16'h0001, 16'hffff);
      for (int i = 0; i < 24; i++) begin
         access(1'($urandom), 16'($urandom), 16'($urandom), 16'($urandom));
      end
      wrap_up();
   end
endmodule
